// file: hdl/hri_regs.vh
// constants for the host-side register interface controller
`ifndef HRI_REGS_VH
`define HRI_REGS_VH
`define HRI_CLK_NS 40
`define HRI_T_SETUP_NS 10
`define HRI_T_OE_NS 30
`define HRI_T_DVALID_NS 10
`define HRI_T_SEL_NS 10
`define HRI_T_GAP_NS 40
`define HRI_T_SCK_HI_NS 32
`define HRI_T_SCK_LO_NS 10
`define HRI_T_SCK_PER_NS 80
`define HRI_CYC_UP(t) (((t) + `HRI_CLK_NS - 1) / `HRI_CLK_NS)
`define HRI_SETUP_CYC `HRI_CYC_UP(`HRI_T_SETUP_NS)
`define HRI_OE_CYC `HRI_CYC_UP(`HRI_T_OE_NS + `HRI_T_DVALID_NS)
`define HRI_SEL_CYC `HRI_CYC_UP(`HRI_T_SEL_NS)
`define HRI_GAP_CYC `HRI_CYC_UP(`HRI_T_GAP_NS)
`define HRI_SCK_HI_CYC `HRI_CYC_UP(`HRI_T_SCK_HI_NS)
`define HRI_SCK_LO_CYC 2
`define HRI_SYNC_CYC 2
`define HRI_FRAME_BITS 15
`define HRI_RW_READ 1'b1
`define HRI_RW_WRITE 1'b0
`define HRI_PORT_A 1'b0
`define HRI_PORT_B 1'b1
`endif

// file: hdl/hri_host.v
// host controller driving the device's parallel and serial register ports
`include "hri_regs.vh"
module hri_host (
  input wire i_clk,
  input wire i_rst,
  input wire i_req,
  input wire i_mode_serial,
  input wire i_port,
  input wire i_rw,
  input wire i_keep,
  input wire [4:0] i_addr,
  input wire [7:0] i_wdata,
  output wire o_busy,
  output reg o_done,
  output reg [7:0] o_rdata,
  output reg o_rpar_ok,
  output reg o_ack_ok,
  output reg o_chip_enable_n,
  output reg o_out_enable_n,
  output reg o_write_enable_n,
  output reg [4:0] o_addr,
  output reg [7:0] o_data_out,
  output reg o_data_oe,
  input wire [7:0] i_data_in,
  output reg o_parity_pin_out,
  output reg o_parity_pin_oe,
  input wire i_parity_pin_in,
  input wire i_ack_n,
  output reg o_port_select_a_n,
  output reg o_port_select_b_n,
  output reg o_frame_select_a_n,
  output reg o_frame_select_b_n,
  output reg o_serial_clock_a,
  output reg o_serial_clock_b,
  output reg o_mosi_a,
  output reg o_mosi_b,
  input wire i_miso_a,
  input wire i_miso_b
);
  localparam S_IDLE = 4'h0;
  localparam S_PSET = 4'h1;
  localparam S_POE = 4'h2;
  localparam S_PWE = 4'h3;
  localparam S_SSEL = 4'h4;
  localparam S_SLO = 4'h5;
  localparam S_SHI = 4'h6;
  localparam S_SEND = 4'h7;
  localparam S_GAP = 4'h8;
  localparam S_PEND = 4'h9;

  reg [3:0] st_q;
  reg [3:0] cnt_q;
  reg [3:0] bit_q;
  reg [14:0] sh_q;
  reg [7:0] rx_q;
  reg port_q;
  reg [1:0] ack_s;
  reg [1:0] miso_a_s;
  reg [1:0] miso_b_s;
  reg [5:0] hdr_q;
  reg [8:0] din_s0, din_s1;
  reg held_q;
  wire ack_sync = ack_s[1];
  // each pin synchronised before the port mux reads it
  wire miso_sync = (port_q == `HRI_PORT_B) ? miso_b_s[1] : miso_a_s[1];
  wire frame_par = ^{i_rw, i_addr, i_wdata};
  wire par_par = ^{i_addr, i_wdata};

  assign o_busy = (st_q != S_IDLE) && (st_q != S_PEND);

  // every pin input passes two flops before use
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_s <= 2'h3;
      miso_a_s <= 2'h0;
      miso_b_s <= 2'h0;
      din_s0 <= 9'h000;
      din_s1 <= 9'h000;
    end else begin
      ack_s <= {ack_s[0], i_ack_n};
      miso_a_s <= {miso_a_s[0], i_miso_a};
      miso_b_s <= {miso_b_s[0], i_miso_b};
      din_s0 <= {i_parity_pin_in, i_data_in};
      din_s1 <= din_s0;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= 15'h0000;
      rx_q <= 8'h00;
      hdr_q <= 6'h00;
      port_q <= 1'b0;
      held_q <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_rpar_ok <= 1'b0;
      o_ack_ok <= 1'b0;
      o_chip_enable_n <= 1'b1;
      o_out_enable_n <= 1'b1;
      o_write_enable_n <= 1'b1;
      o_addr <= 5'h00;
      o_data_out <= 8'h00;
      o_data_oe <= 1'b0;
      o_parity_pin_out <= 1'b0;
      o_parity_pin_oe <= 1'b0;
      o_port_select_a_n <= 1'b1;
      o_port_select_b_n <= 1'b1;
      o_frame_select_a_n <= 1'b1;
      o_frame_select_b_n <= 1'b1;
      o_serial_clock_a <= 1'b0;
      o_serial_clock_b <= 1'b0;
      o_mosi_a <= 1'b0;
      o_mosi_b <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (st_q)
        S_IDLE, S_PEND: begin
          if (i_req && !i_mode_serial) begin
            // chip enable low, address and strobes set in one step
            o_port_select_a_n <= 1'b1;
            o_port_select_b_n <= 1'b1;
            o_chip_enable_n <= 1'b0;
            o_write_enable_n <= 1'b1;
            o_out_enable_n <= 1'b1;
            o_addr <= i_addr;
            o_data_out <= i_wdata;
            o_data_oe <= (i_rw == `HRI_RW_WRITE);
            o_parity_pin_out <= par_par;
            o_parity_pin_oe <= (i_rw == `HRI_RW_WRITE);
            sh_q[14] <= i_rw;
            cnt_q <= 4'h0;
            st_q <= S_PSET;
          end else if (i_req && i_mode_serial) begin
            port_q <= i_port;
            // only the target port select low; select change aborts others
            o_port_select_a_n <= (i_port != `HRI_PORT_A);
            o_port_select_b_n <= (i_port != `HRI_PORT_B);
            o_chip_enable_n <= 1'b1;
            sh_q <= {i_rw, i_addr, i_wdata, frame_par};
            hdr_q <= {i_rw, i_addr};
            bit_q <= 4'h0;
            cnt_q <= 4'h0;
            // already selected from a back-to-back frame skips the select wait
            st_q <= (st_q == S_PEND && held_q && port_q == i_port) ? S_GAP : S_SSEL;
          end else if (st_q == S_PEND && !i_keep) begin
            o_chip_enable_n <= 1'b1;
            o_port_select_a_n <= 1'b1;
            o_port_select_b_n <= 1'b1;
            held_q <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        S_PSET: begin
          // address setup before the strobe
          cnt_q <= cnt_q + 4'h1;
          if (sh_q[14] == `HRI_RW_READ && cnt_q + 4'h1 >= `HRI_SETUP_CYC) begin
            cnt_q <= 4'h0;
            o_out_enable_n <= 1'b0;
            st_q <= S_POE;
          end else if (sh_q[14] != `HRI_RW_READ && cnt_q + 4'h1 >= `HRI_SETUP_CYC + `HRI_SYNC_CYC) begin
            // accept needs two sync cycles, else it shows the old lines
            cnt_q <= 4'h0;
            // write strobe only when accept shows good parity
            o_ack_ok <= !ack_sync;
            if (!ack_sync) o_write_enable_n <= 1'b0;
            st_q <= S_PWE;
          end
        end
        S_POE: begin
          // oe low long enough, plus sync delay, before capture
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q >= `HRI_OE_CYC + 1) begin
            o_rdata <= din_s1[7:0];
            o_rpar_ok <= ~^{o_addr, din_s1};
            o_out_enable_n <= 1'b1;
            o_done <= 1'b1;
            held_q <= 1'b1;
            st_q <= S_PEND;
          end
        end
        S_PWE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q >= 4'h1) begin
            o_write_enable_n <= 1'b1;
            o_data_oe <= 1'b0;
            o_parity_pin_oe <= 1'b0;
            o_done <= 1'b1;
            held_q <= 1'b1;
            st_q <= S_PEND;
          end
        end
        S_SSEL, S_GAP: begin
          // select-to-frame and inter-frame gaps
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q + 4'h1 >= ((st_q == S_GAP) ? `HRI_GAP_CYC : `HRI_SEL_CYC)) begin
            cnt_q <= 4'h0;
            o_frame_select_a_n <= (port_q != `HRI_PORT_A);
            o_frame_select_b_n <= (port_q != `HRI_PORT_B);
            st_q <= S_SLO;
          end
        end
        S_SLO: begin
          // data set a full cycle before the rise for setup, msb first
          o_mosi_a <= sh_q[14];
          o_mosi_b <= sh_q[14];
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q + 4'h1 >= `HRI_SCK_LO_CYC) begin
            cnt_q <= 4'h0;
            // rising edge: device captures input, host samples output
            o_serial_clock_a <= (port_q == `HRI_PORT_A);
            o_serial_clock_b <= (port_q == `HRI_PORT_B);
            st_q <= S_SHI;
          end
        end
        S_SHI: begin
          // high phase held two cycles (80ns), so with the two-cycle low phase the period is 160ns
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'h0) begin
            if (bit_q >= 4'h6 && bit_q <= 4'hD) rx_q <= {rx_q[6:0], miso_sync};
            if (bit_q == 4'hE) o_rpar_ok <= ~^{hdr_q, rx_q, miso_sync};
          end
          if (cnt_q + 4'h1 >= `HRI_SCK_HI_CYC + 4'h1) begin
            cnt_q <= 4'h0;
            o_serial_clock_a <= 1'b0;
            o_serial_clock_b <= 1'b0;
            sh_q <= {sh_q[13:0], 1'b0};
            bit_q <= bit_q + 4'h1;
            // exactly fifteen clocks per frame
            st_q <= (bit_q == `HRI_FRAME_BITS - 1) ? S_SEND : S_SLO;
          end
        end
        S_SEND: begin
          // wait for miso to cross, then close frame and read accept
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'h3) begin
            o_frame_select_a_n <= 1'b1;
            o_frame_select_b_n <= 1'b1;
          end
          if (cnt_q == 4'h6) begin
            o_rdata <= rx_q;
            // write result only meaningful for writes; bad parity leaves reg
            o_ack_ok <= !ack_sync;
            o_done <= 1'b1;
            held_q <= 1'b1;
            cnt_q <= 4'h0;
            st_q <= S_PEND;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// file: tb/hri_host_properties.sv
// pin timing checker for the host controller
module hri_host_properties(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic o_chip_enable_n,
  input wire logic o_out_enable_n,
  input wire logic [4:0] o_addr,
  input wire logic o_port_select_a_n,
  input wire logic o_port_select_b_n,
  input wire logic o_frame_select_a_n,
  input wire logic o_frame_select_b_n,
  input wire logic o_serial_clock_a,
  input wire logic o_serial_clock_b,
  input wire logic o_mosi_a
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] nb_q;
  logic sk_q;
  wire sck = o_serial_clock_a | o_serial_clock_b;
  // counts clock rises inside a frame
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      nb_q <= 5'h00;
      sk_q <= 1'b0;
    end else begin
      sk_q <= sck;
      nb_q <= (o_frame_select_a_n & o_frame_select_b_n) ? 5'h00 : nb_q + {4'h0, sck & ~sk_q};
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_CE_OE: assert property (!o_out_enable_n |-> !o_chip_enable_n)
    else $error("oe low without ce");
  AST_OE_LEN: assert property ($fell(o_out_enable_n) |-> ##1 !o_out_enable_n)
    else $error("oe pulse short");
  AST_SETUP: assert property ($fell(o_out_enable_n) |-> !$past(o_chip_enable_n) && $stable(o_addr))
    else $error("oe before setup");
  AST_PORT_EXCL: assert property (o_port_select_a_n || o_port_select_b_n)
    else $error("both ports selected");
  AST_FS_SEL: assert property ($fell(o_frame_select_a_n) |-> !$past(o_port_select_a_n) && o_port_select_b_n)
    else $error("frame before select");
  AST_SCK_IDLE: assert property (o_frame_select_a_n |-> !o_serial_clock_a)
    else $error("clock outside frame");
  AST_MOSI: assert property ($rose(o_serial_clock_a) |=> $stable(o_mosi_a))
    else $error("data moved in high phase");
  AST_SCK_HI: assert property ($rose(o_serial_clock_a) |-> ##1 o_serial_clock_a)
    else $error("clock high phase short");
  AST_BITS15: assert property ($rose(o_frame_select_a_n & o_frame_select_b_n) |-> nb_q == 5'h0F)
    else $error("frame not 15 bits");
endmodule
bind hri_host hri_host_properties u_hri_host_properties(.*);

// file: tb/hri_dev_model.sv
// behavioural device on the far side of both ports
module hri_dev_model(
  input wire logic i_bad,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [4:0] i_a,
  input wire logic [7:0] i_d,
  input wire logic i_pty,
  input wire logic i_psa_n,
  input wire logic i_psb_n,
  input wire logic i_fsa_n,
  input wire logic i_fsb_n,
  input wire logic i_scka,
  input wire logic i_sckb,
  input wire logic i_mosi,
  output wire logic [7:0] o_d,
  output wire logic o_drv,
  output wire logic o_pty,
  output wire logic o_ack_n,
  output logic o_miso = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rg [32];
  logic [14:0] sr = 15'h0000;
  logic [4:0] ra = 5'h00;
  logic ack_q = 1'b1;
  logic rd = 1'b0;
  int n = 0;
  wire ser = i_psa_n ^ i_psb_n;
  wire fs = i_psa_n ? i_fsb_n : i_fsa_n;
  wire sck = i_psa_n ? i_sckb : i_scka;
  // i_bad forces a parity failure on command
  wire pok = ~^{i_a, i_d, i_pty} & ~i_bad;
  wire [8:0] rx = {rg[ra], ^{rd, ra, rg[ra]}};
  initial foreach (rg[j]) rg[j] = 8'h00;
  assign o_drv = !i_ce_n && !i_oe_n && !ser;
  // released bus shows the inverse, never a stale copy
  assign o_d = o_drv ? rg[i_a] : ~rg[i_a];
  assign o_pty = ^{i_a, rg[i_a]};
  assign o_ack_n = ser ? ack_q : ~pok;
  always @(negedge i_we_n) if (!i_ce_n && !ser && pok) rg[i_a] = i_d;
  always @(negedge fs) begin
    n = 0;
    rd = 1'b0;
    ack_q = 1'b1;
  end
  always @(posedge sck) if (!fs && ser) begin
    sr = {sr[13:0], i_mosi};
    n++;
  end
  always @(negedge sck) begin
    if (n == 6) begin
      ra = sr[4:0];
      rd = sr[5];
    end
    o_miso <= (rd && n > 5 && n < 15) ? rx[14-n] : ~o_miso;
  end
  always @(posedge fs) if (ser && n == 15 && !sr[14] && !(^sr) && !i_bad) begin
    rg[sr[13:9]] = sr[8:1];
    ack_q = 1'b0;
  end
endmodule

// file: tb/host_register_interface_bench.sv
// self-checking bench for the host controller
module host_register_interface_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_req = 1'b0;
  logic i_mode_serial = 1'b0;
  logic i_port = 1'b0;
  logic i_rw = 1'b0;
  logic i_keep = 1'b0;
  logic bad = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] mem [32];
  int errors = 0;
  int checks = 0;
  wire o_busy, o_done, o_ack_ok, ce_n, oe_n, we_n, d_oe, p_out, p_oe, psa_n, psb_n;
  wire fsa_n, fsb_n, scka, sckb, mo_a, mo_b, miso, ack_n, dv, dp, o_rpar_ok;
  wire [7:0] o_rdata, d_out, dd;
  wire [4:0] a;
  always #20 i_clk = ~i_clk;
  hri_host u_hri_host(.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_mode_serial(i_mode_serial),
    .i_port(i_port), .i_rw(i_rw), .i_keep(i_keep), .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy),
    .o_done(o_done), .o_rdata(o_rdata), .o_rpar_ok(o_rpar_ok), .o_ack_ok(o_ack_ok), .o_chip_enable_n(ce_n),
    .o_out_enable_n(oe_n), .o_write_enable_n(we_n), .o_addr(a), .o_data_out(d_out), .o_data_oe(d_oe),
    .i_data_in(d_oe ? d_out : dd), .o_parity_pin_out(p_out), .o_parity_pin_oe(p_oe),
    .i_parity_pin_in(p_oe ? p_out : dp), .i_ack_n(ack_n), .o_port_select_a_n(psa_n),
    .o_port_select_b_n(psb_n), .o_frame_select_a_n(fsa_n), .o_frame_select_b_n(fsb_n),
    .o_serial_clock_a(scka), .o_serial_clock_b(sckb), .o_mosi_a(mo_a), .o_mosi_b(mo_b),
    .i_miso_a(miso), .i_miso_b(miso));
  hri_dev_model u_hri_dev_model(.i_bad(bad), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_a(a),
    .i_d(d_oe ? d_out : dd), .i_pty(p_oe ? p_out : dp), .i_psa_n(psa_n), .i_psb_n(psb_n),
    .i_fsa_n(fsa_n), .i_fsb_n(fsb_n), .i_scka(scka), .i_sckb(sckb), .i_mosi(psa_n ? mo_b : mo_a),
    .o_d(dd), .o_drv(dv), .o_pty(dp), .o_ack_n(ack_n), .o_miso(miso));
  task give_verdict;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task run(input logic s, p, r, k, b, input logic [4:0] ad, input logic [7:0] wd);
    int n;
    @(posedge i_clk);
    i_mode_serial <= s;
    i_port <= p;
    i_rw <= r;
    i_keep <= k;
    bad <= b;
    i_addr <= ad;
    i_wdata <= wd;
    i_req <= 1'b1;
    @(posedge i_clk);
    i_req <= 1'b0;
    @(negedge i_clk);
    cmp("busy", 8'h01, {7'h00, o_busy});
    // bounded wait on the done pulse
    for (n = 0; n < 300 && o_done !== 1'b1; n++) @(negedge i_clk);
    if (n == 300) errors++;
  endtask
  initial begin
    logic [4:0] ad;
    logic [7:0] wd;
    logic b;
    void'($urandom(32'h4E962353));
    foreach (mem[j]) mem[j] = 8'h00;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      ad = $urandom;
      wd = $urandom;
      b = (i % 5 == 4);
      // keep on the writes with bit 2 of i set, so the read follows without releasing select
      run(i[0], i[1], 1'b0, i[2], b, ad, wd);
      cmp("write accept", {7'h00, !b}, {7'h00, o_ack_ok});
      if (!b) mem[ad] = wd;
      run(i[0], i[1], 1'b1, 1'b0, 1'b0, ad, wd);
      cmp("read byte", mem[ad], o_rdata);
      cmp("read parity", 8'h01, {7'h00, o_rpar_ok});
    end
    give_verdict;
  end
  // host must never drive the data lines while the device does
  always @(negedge i_clk) if (dv) cmp("bus contention", 8'h00, {7'h00, d_oe});
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    give_verdict;
  end
endmodule
